// ### src/omc_out_drive.sv
// Per-output mode decode: static low, static high or dynamic source
`timescale 1ns/1ps
module omc_out_drive
    import omc_pkg::*;
#(
    parameter int NUM_OUT = OMC_NUM_OUT,
    parameter int NUM_SRC = OMC_NUM_SRC
) (
    // Mode and source-select fields, one per output
    input wire logic [NUM_OUT*OMC_FIELD_W-1:0] mode_fields,
    input wire logic [NUM_OUT*OMC_SRC_W-1:0] src_fields,
    // Synchronised dynamic sources
    input wire logic [NUM_SRC-1:0] dyn_src,
    // Next line levels and reserved-code flags
    output logic [NUM_OUT-1:0] line_next,
    output logic [NUM_OUT-1:0] rsvd_seen
);
    genvar g;
    // One decoder per output line
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            logic [1:0] mode;
            logic [OMC_SRC_W-1:0] sel;
            assign mode = mode_fields[g*OMC_FIELD_W +: OMC_FIELD_W];
            assign sel = src_fields[g*OMC_SRC_W +: OMC_SRC_W];
            always_comb begin
                rsvd_seen[g] = 1'b0;
                case (mode)
                    OMC_MODE_LOW: line_next[g] = 1'b0; // R3
                    OMC_MODE_HIGH: line_next[g] = 1'b1; // R3
                    OMC_MODE_DYN: line_next[g] = dyn_src[sel]; // R4
                    default: begin
                        // Reserved code parks the line low rather than guessing
                        line_next[g] = 1'b0;
                        rsvd_seen[g] = 1'b1;
                    end
                endcase
            end
        end
    endgenerate
endmodule

// ### src/omc_pkg.sv
// Constants for the output mode select block, group C
package omc_pkg;
    // Register map (byte addresses on the AHB-Lite slave)
    localparam logic [7:0] OMC_MODE_ADDR = 8'h00;
    localparam logic [7:0] OMC_SRC_ADDR = 8'h04;
    localparam logic [7:0] OMC_STATUS_ADDR = 8'h08;
    localparam int OMC_ADDR_W = 8;
    // Output counts and field layout
    localparam int OMC_NUM_ISO = 8;
    localparam int OMC_NUM_OC = 4;
    localparam int OMC_NUM_OUT = 12;
    localparam int OMC_FIELD_W = 2;
    localparam int OMC_OC_LSB = 16;
    localparam int OMC_OC_SRC_BASE = 8;
    localparam int OMC_USED_BITS = 24;
    // Source select: one 2-bit field per output, index into four dynamic sources
    localparam int OMC_SRC_W = 2;
    localparam int OMC_NUM_SRC = 4;
    localparam logic [31:0] OMC_USED_MASK = 32'h00FFFFFF;
    // Reset values
    localparam logic [31:0] OMC_MODE_RESET = 32'h00000000;
    localparam logic [31:0] OMC_SRC_RESET = 32'h00000000;
    // Mode encodings
    localparam logic [1:0] OMC_MODE_LOW = 2'h0;
    localparam logic [1:0] OMC_MODE_HIGH = 2'h1;
    localparam logic [1:0] OMC_MODE_DYN = 2'h2;
    localparam logic [1:0] OMC_MODE_RSVD = 2'h3;
    // AHB transfer type
    localparam logic [1:0] OMC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] OMC_HTRANS_SEQ = 2'h3;
endpackage

// ### src/omc_top.sv
// Output mode select group C: AHB-Lite registers and twelve output lines
`timescale 1ns/1ps
// How it works
// R1 - Eight 2-bit read/write mode fields for isolated outputs 0..7 sit at bits 2n+1..2n.
// R2 - Four 2-bit read/write mode fields for open-collector outputs 0..3 sit at bits 17..16 to 23..22.
// R3 - Mode 00b drives the output low and mode 01b drives it high.
// R4 - Mode 10b drives the output from its source-select field; software never writes 11b.
// R5 - Open-collector output n takes its dynamic source from source-select field n plus 8.
// R6 - Bits 31..24 of the mode register read as zero and ignore writes.
module omc_top
    import omc_pkg::*;
#(
    parameter int NUM_SRC = OMC_NUM_SRC
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RESET_N,
    // AHB-Lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // Dynamic sources from pins
    input wire logic [NUM_SRC-1:0] DYN_SRC,
    // Output lines to the I/O box
    output logic [OMC_NUM_ISO-1:0] ISOLATED_OUT,
    output logic [OMC_NUM_OC-1:0] OPEN_COLLECTOR_OUT
);
    // Register map, low address byte only:
    //   mode word   - twelve 2-bit mode fields, bits 31..24 reserved
    //   select word - twelve 2-bit source selects, one per line
    //   status word - line levels in 11..0, reserved-code flags in 23..12, read only
    // Latency: a line follows its mode one edge after the write lands, and a
    // dynamic pin reaches its line three edges after it changes at the pin.

    // Register file
    logic [31:0] mode_reg;
    logic [31:0] mode_next;
    logic [31:0] src_reg;
    logic [31:0] src_next;
    // Bus pipeline: pending write, its address, read data and the response
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [OMC_ADDR_W-1:0] wr_addr_reg;
    logic [OMC_ADDR_W-1:0] wr_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic hreadyout_reg;
    logic hreadyout_next;
    logic hresp_reg;
    logic hresp_next;
    // Output lines and reserved-code flags
    logic [OMC_NUM_OUT-1:0] line_dec;
    logic [OMC_NUM_OUT-1:0] line_reg;
    logic [OMC_NUM_OUT-1:0] line_next;
    logic [OMC_NUM_OUT-1:0] rsvd_seen;
    logic [OMC_NUM_OUT-1:0] rsvd_reg;
    logic [OMC_NUM_OUT-1:0] rsvd_next;
    // Two-stage synchroniser for the dynamic source pins
    logic [NUM_SRC-1:0] src_meta_reg;
    logic [NUM_SRC-1:0] src_meta_next;
    logic [NUM_SRC-1:0] src_sync_reg;
    logic [NUM_SRC-1:0] src_sync_next;
    // Bus decode and decoder inputs
    logic access;
    logic [OMC_ADDR_W-1:0] bus_addr;
    logic wr_mode_hit;
    logic wr_src_hit;
    logic [31:0] wr_data;
    logic [31:0] mode_view;
    logic [31:0] src_view;
    logic [OMC_NUM_OUT*OMC_FIELD_W-1:0] mode_fields;
    logic [OMC_NUM_OUT*OMC_SRC_W-1:0] src_fields;

    // A transfer is taken only when selected, active and the bus is ready
    assign access = HSEL && HREADY && (HTRANS == OMC_HTRANS_NONSEQ || HTRANS == OMC_HTRANS_SEQ);
    // Only the low address byte is decoded, so the map repeats across the slave's window
    assign bus_addr = HADDR[OMC_ADDR_W-1:0];

    // A write lands in its data phase, addressed by what was taken in the address phase
    assign wr_mode_hit = wr_pend_reg && (wr_addr_reg == OMC_MODE_ADDR);
    assign wr_src_hit = wr_pend_reg && (wr_addr_reg == OMC_SRC_ADDR);
    // Reserved bits are dropped on the way in, so they can never read back as set
    assign wr_data = HWDATA & OMC_USED_MASK; // R6

    // A read whose address phase overlaps a write's data phase to the same register
    // sees the new word; without this a pipelined master would read back stale data
    assign mode_view = wr_mode_hit ? wr_data : mode_reg;
    assign src_view = wr_src_hit ? wr_data : src_reg;

    // Isolated fields in bits 15..0, open-collector fields in 23..16
    assign mode_fields = mode_reg[OMC_USED_BITS-1:0]; // R1 R2
    // Select fields 8..11 sit beside decoder lines 8..11, so collector n reads field n plus 8
    assign src_fields = src_reg[OMC_NUM_OUT*OMC_SRC_W-1:0]; // R5

    // Register file next values; one register at most is written per cycle
    always_comb begin
        mode_next = mode_reg;
        src_next = src_reg;
        if (wr_mode_hit) begin
            mode_next = wr_data; // R1 R2 R6
        end else if (wr_src_hit) begin
            src_next = wr_data;
        end
    end

    // Register file; both registers clear so every line starts low
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            mode_reg <= OMC_MODE_RESET;
            src_reg <= OMC_SRC_RESET;
        end else begin
            mode_reg <= mode_next;
            src_reg <= src_next;
        end
    end

    // Bus pipeline next values; read data is fetched in the address phase so that it
    // stands for the whole data phase and holds until the next read
    always_comb begin
        wr_pend_next = access && HWRITE;
        wr_addr_next = wr_addr_reg;
        hrdata_next = hrdata_reg;
        // Zero-wait slave with no error cases: unmapped accesses read zero and drop writes
        // Only whole-word transfers are expected, so the transfer size is not decoded
        hreadyout_next = 1'b1;
        hresp_next = 1'b0;
        if (access) begin
            wr_addr_next = bus_addr;
        end
        if (access && !HWRITE) begin
            if (bus_addr == OMC_MODE_ADDR) begin
                hrdata_next = mode_view; // R6
            end else if (bus_addr == OMC_SRC_ADDR) begin
                hrdata_next = src_view;
            end else if (bus_addr == OMC_STATUS_ADDR) begin
                hrdata_next = {8'h00, rsvd_reg, line_reg};
            end else begin
                hrdata_next = 32'h00000000;
            end
        end
    end

    // Bus pipeline; ready stays high through reset so the fabric is never stalled
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= OMC_MODE_ADDR;
            hrdata_reg <= 32'h00000000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= hreadyout_next;
            hresp_reg <= hresp_next;
        end
    end

    // Synchroniser next values: the pins are asynchronous, so only the second stage
    // is ever read; a change reaches the decoder one edge after it is sampled
    // Limitation: a pin pulse shorter than one clock period can be missed
    always_comb begin
        src_meta_next = DYN_SRC;
        src_sync_next = src_meta_reg;
    end

    // Synchroniser stages
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            src_meta_reg <= '0;
            src_sync_reg <= '0;
        end else begin
            src_meta_reg <= src_meta_next;
            src_sync_reg <= src_sync_next;
        end
    end

    // Per-output decode of the mode and source-select fields
    omc_out_drive #(
        .NUM_OUT(OMC_NUM_OUT),
        .NUM_SRC(NUM_SRC)
    ) u_drive (
        .mode_fields(mode_fields),
        .src_fields(src_fields),
        .dyn_src(src_sync_reg),
        .line_next(line_dec),
        .rsvd_seen(rsvd_seen)
    );

    // Line next values; the flags record any field that holds the reserved code,
    // which software must never write, so the line is parked low instead
    always_comb begin
        line_next = line_dec; // R3 R4
        rsvd_next = rsvd_seen;
    end

    // Output lines change one edge after the register write and never glitch,
    // since the decode settles between edges
    always_ff @(posedge CLK) begin
        if (!RESET_N) begin
            line_reg <= '0;
            rsvd_reg <= '0;
        end else begin
            line_reg <= line_next;
            rsvd_reg <= rsvd_next;
        end
    end

    // Every port is driven straight from a flop
    assign HRDATA = hrdata_reg;
    assign HREADYOUT = hreadyout_reg;
    assign HRESP = hresp_reg;
    assign ISOLATED_OUT = line_reg[OMC_NUM_ISO-1:0]; // R1 R3
    assign OPEN_COLLECTOR_OUT = line_reg[OMC_NUM_OUT-1:OMC_NUM_ISO]; // R2 R5
endmodule

// ### verif/omc_box_model.sv
// Source pins of the I/O box
`timescale 1ns/1ps
module omc_box_model (
    // Clock, wanted pattern and pins
    input wire logic CLK,
    input wire logic [3:0] pat,
    output logic [3:0] DYN_SRC
);
    // Pins change only after an edge, like a real driver
    always_ff @(posedge CLK) begin
        DYN_SRC <= pat;
    end
endmodule

// ### verif/omc_chk.sv
// Port checker for the output mode block
`timescale 1ns/1ps
module omc_chk
    import omc_pkg::*;
(
    // Watched top-level ports
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic [7:0] ISOLATED_OUT,
    input wire logic [3:0] OPEN_COLLECTOR_OUT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    // Mode register accesses, ending at the data-phase edge
    sequence s_acc; HSEL && HREADY && HTRANS[1] && HADDR[7:0] == OMC_MODE_ADDR; endsequence
    sequence s_wr; s_acc ##0 HWRITE ##1 1'b1; endsequence
    sequence s_rd; s_acc ##0 !HWRITE ##1 1'b1; endsequence
    property p_ready; HREADYOUT; endproperty
    a_ready: assert property (p_ready) else $error("wait state seen");
    property p_okay; !HRESP; endproperty
    a_okay: assert property (p_okay) else $error("error response seen");
    property p_rst; $rose(RESET_N) |-> ISOLATED_OUT == 8'h00 && OPEN_COLLECTOR_OUT == 4'h0; endproperty
    a_rst: assert property (p_rst) else $error("lines not low after reset");
    property p_iso_low; s_wr ##0 HWDATA[1:0] == OMC_MODE_LOW |-> ##2 !ISOLATED_OUT[0]; endproperty
    a_iso_low: assert property (p_iso_low) else $error("isolated 0 not low");
    property p_iso_high; s_wr ##0 HWDATA[15:14] == OMC_MODE_HIGH |-> ##2 ISOLATED_OUT[7]; endproperty
    a_iso_high: assert property (p_iso_high) else $error("isolated 7 not high");
    property p_oc_high; s_wr ##0 HWDATA[17:16] == OMC_MODE_HIGH |-> ##2 OPEN_COLLECTOR_OUT[0]; endproperty
    a_oc_high: assert property (p_oc_high) else $error("collector 0 not high");
    property p_oc_low; s_wr ##0 HWDATA[23:22] == OMC_MODE_LOW |-> ##2 !OPEN_COLLECTOR_OUT[3]; endproperty
    a_oc_low: assert property (p_oc_low) else $error("collector 3 not low");
    property p_rsvd; s_rd |-> HRDATA[31:24] == 8'h00; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits read set");
endmodule

// ### verif/output_mode_select_group_c_bench.sv
// Testbench for the output mode block
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin num_errors++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module output_mode_select_group_c_bench;
    import omc_pkg::*;
    logic CLK = 1'b0, RESET_N = 1'b0, HSEL = 1'b0, HWRITE = 1'b0, rdy, resp;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, r, m, s, HRDATA_w;
    logic [1:0] HTRANS = 2'h0;
    logic [3:0] pat = 4'h0, dyn, oc;
    logic [7:0] iso;
    int num_errors = 0, checked = 0;
    // Free-running clock
    always #4 CLK = ~CLK;
    omc_top uut (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(rdy), .HRDATA(HRDATA_w),
        .HREADYOUT(rdy), .HRESP(resp), .DYN_SRC(dyn), .ISOLATED_OUT(iso),
        .OPEN_COLLECTOR_OUT(oc));
    omc_box_model box (.CLK(CLK), .pat(pat), .DYN_SRC(dyn));
    task wrap_up;
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Bounded wait for the slave to accept a phase
    task wait_rdy;
        int i;
        i = 0;
        @(posedge CLK);
        while (rdy !== 1'b1) begin
            if (++i > 50) begin num_errors++; wrap_up; end
            @(posedge CLK);
        end
    endtask
    // One single word transfer; read data lands in r
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1; HTRANS <= OMC_HTRANS_NONSEQ; HADDR <= {24'h000000, a}; HWRITE <= w;
        wait_rdy;
        HTRANS <= 2'h0; HWDATA <= d;
        wait_rdy;
        r = HRDATA_w;
    endtask
    // Software never writes the reserved code, so it is folded to dynamic
    function automatic logic [31:0] legal(logic [31:0] x);
        for (int n = 0; n < 12; n++) if (x[2*n +: 2] == 2'h3) x[2*n +: 2] = 2'h2;
        return x;
    endfunction
    // Line n uses select field n, so collector n lands on field n plus 8
    function automatic logic [11:0] lines(logic [31:0] md, logic [31:0] sr, logic [3:0] dv);
        for (int n = 0; n < 12; n++) lines[n] = md[2*n +: 2] == OMC_MODE_HIGH ||
            (md[2*n +: 2] == OMC_MODE_DYN && dv[sr[2*n +: 2]]);
    endfunction
    // Corners first: all low with reserved bits set, all high, all dynamic
    initial begin
        void'($urandom(97152));
        repeat (10) @(posedge CLK);
        RESET_N <= 1'b1;
        xfer(1'b0, OMC_MODE_ADDR, 32'h0);
        `CHK(r, OMC_MODE_RESET)
        xfer(1'b0, 8'h0C, 32'h0);
        `CHK(r, 32'h00000000)
        for (int k = 0; k < 40; k++) begin
            m = k < 3 ? {8'hFF, {12{2'(k)}}} : $urandom;
            m = legal(m);
            s = $urandom;
            pat <= 4'($urandom);
            xfer(1'b1, OMC_SRC_ADDR, s);
            xfer(1'b1, OMC_MODE_ADDR, m);
            repeat (5) @(posedge CLK);
            `CHK({oc, iso}, lines(m, s, pat))
            xfer(1'b0, OMC_MODE_ADDR, 32'h0);
            `CHK(r, m & OMC_USED_MASK)
            xfer(1'b0, OMC_SRC_ADDR, 32'h0);
            `CHK(r, s & OMC_USED_MASK)
            // Status word: line levels match the expected lines, no reserved-code flags for legal writes
            xfer(1'b0, OMC_STATUS_ADDR, 32'h0);
            `CHK(r, {20'h00000, lines(m, s, pat)})
        end
        // Reset in mid-run: lines drop and the mode word returns to its reset value
        RESET_N <= 1'b0;
        repeat (2) @(posedge CLK);
        RESET_N <= 1'b1;
        `CHK({oc, iso}, 12'h000)
        xfer(1'b0, OMC_MODE_ADDR, 32'h0);
        `CHK(r, OMC_MODE_RESET)
        wrap_up;
    end
endmodule
bind omc_top omc_chk chk (.CLK(CLK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ISOLATED_OUT(ISOLATED_OUT),
    .OPEN_COLLECTOR_OUT(OPEN_COLLECTOR_OUT));
